// [pdm_defines.svh]
// constants of the power-down controller: register offsets, field
// positions, reset values, masks, gate channel numbers and timing counts.
// assumes: included by bare name from every file that needs it.
// How it works
// [RULE_01] sleep with standby clear enters sleep
// [RULE_02] sleep with standby set enters standby
// [RULE_03] sleep halts cpu; standby halts everything
// [RULE_04] float bit picks hold or high-z pins
// [RULE_05] software stops watchdog before setting standby
// [RULE_06] break stop gates clock, keeps registers
// [RULE_07] software never stops active break controller
// [RULE_08] dma stop freezes state, resumes from it
// [RULE_09] dma stop waits for idle dma
// [RULE_10] dsp stop keeps last result
// [RULE_11] no dsp operands while dsp stopped
// [RULE_12] timer stop resets timer, restarts fresh
// [RULE_13] reserved bits 2,0 read zero
// [RULE_14] control one is 8-bit, resets zero
// [RULE_15] each stop bit gates own clock only
// [RULE_16] interrupt, address error, resets end sleep
// [RULE_17] nmi blocked at sleep plus 5 cycles
// [RULE_18] gating glitch-free, whole cycles only
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

`define PDM_ADDR_CTL_ONE 32'hFFFF_FE91
`define PDM_ADDR_CTL_TWO 32'hFFFF_FE93
`define PDM_ADDR_STATUS 32'hFFFF_FE95

`define PDM_CTL_ONE_RST 8'h00
`define PDM_CTL_TWO_RST 8'h00
`define PDM_CTL_ONE_WMASK 8'hFA
`define PDM_CTL_TWO_WMASK 8'h3F

`define PDM_BIT_STANDBY_SELECT 7
`define PDM_BIT_OUTPUT_FLOAT 6
`define PDM_BIT_BREAK_STOP 5
`define PDM_BIT_DMA_STOP 4
`define PDM_BIT_DSP_STOP 3
`define PDM_BIT_FREE_TIMER_STOP 1

`define PDM_GATE_COUNT 5
`define PDM_CH_CPU 0
`define PDM_CH_DSP 1
`define PDM_CH_DMA 2
`define PDM_CH_BREAK 3
`define PDM_CH_TIMER 4

`define PDM_NMI_BLOCK_CYC 5

`endif

// [pdm_pkg.sv]
// types of the power-down controller.
// assumes: nothing beyond the compiler.
`default_nettype none
package pdm_pkg;
   typedef enum logic [1:0] {
      st_run,
      st_sleep,
      st_standby
   } pdm_mode_t;
endpackage : pdm_pkg
`default_nettype wire

// [pdm_gate_if.sv]
// bundle between the controller and its clock gate bank.
// assumes: both ends run on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface pdm_gate_if #(parameter int N = 5);
   logic [N-1:0] stop_req;
   logic [N-1:0] run_en;
   logic [N-1:0] gclk;
   modport ctrl (output stop_req, input run_en, input gclk);
   modport gate (input stop_req, output run_en, output gclk);
endinterface : pdm_gate_if
`default_nettype wire

// [pdm_clk_gate.sv]
// bank of latch-based clock gates, one per gated module.
// assumes: stop requests are synchronous to mclk_in.
`timescale 1ns/1ps
`default_nettype none
module pdm_clk_gate #(
   parameter int N = 5
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   pdm_gate_if.gate gate_if
);
   logic [N-1:0] run_en_ff;
   logic [N-1:0] en_lat;

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         run_en_ff <= '1;
      else
         run_en_ff <= ~gate_if.stop_req;
   end

   // enable only moves while the clock is low, so no runt pulse escapes
   always_latch
   begin
      if (!mclk_in)
         en_lat = run_en_ff; // see [RULE_18]
   end

   assign gate_if.gclk = {N{mclk_in}} & en_lat; // see [RULE_15]
   assign gate_if.run_en = run_en_ff;
endmodule : pdm_clk_gate
`default_nettype wire

// [pdm_power_ctrl.sv]
// power-down controller: standby control registers, sleep and standby
// sequencing, nmi blocking window and per-module clock gating.
// assumes: cpu, interrupt and dma signals share mclk_in; nmi and
// manual reset arrive from pins; register bus reads answer next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_power_ctrl #(
   parameter int NMI_BLOCK = `PDM_NMI_BLOCK_CYC
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [31:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic sleep_exec_in,
   input wire logic irq_accept_in,
   input wire logic dma_addr_err_in,
   input wire logic dma_busy_in,
   input wire logic nmi_pin_in,
   input wire logic manual_reset_pin_in,
   output logic nmi_accept_out,
   output logic sleep_mode_out,
   output logic standby_mode_out,
   output logic cpu_halt_out,
   output logic periph_halt_out,
   output logic osc_stop_out,
   output logic pin_float_out,
   output logic pin_hold_out,
   output logic timer_reset_out,
   output logic [5:0] module_stop_two_out,
   output logic cpu_gclk_out,
   output logic dsp_gclk_out,
   output logic dma_gclk_out,
   output logic break_gclk_out,
   output logic timer_gclk_out
);
   localparam int CW = $clog2(NMI_BLOCK + 1);
   localparam logic [CW-1:0] BLOCK_LOAD = CW'(NMI_BLOCK);

   function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] ref_a);
      addr_hit = (a == ref_a);
   endfunction : addr_hit

   // ---- pin synchronisers
   logic [1:0] nmi_sync_ff;
   logic [1:0] mrst_sync_ff;
   logic nmi_prev_ff;

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         nmi_sync_ff <= 2'h0;
         mrst_sync_ff <= 2'h0;
         nmi_prev_ff <= 1'b0;
      end
      else
      begin
         nmi_sync_ff <= {nmi_sync_ff[0], nmi_pin_in};
         mrst_sync_ff <= {mrst_sync_ff[0], manual_reset_pin_in};
         nmi_prev_ff <= nmi_sync_ff[1];
      end
   end

   wire logic nmi_level = nmi_sync_ff[1];
   wire logic nmi_rise = nmi_level & ~nmi_prev_ff;
   wire logic manual_reset = mrst_sync_ff[1];

   // ---- register bus decode
   wire logic hit_one = addr_hit(reg_addr_in, `PDM_ADDR_CTL_ONE);
   wire logic hit_two = addr_hit(reg_addr_in, `PDM_ADDR_CTL_TWO);
   wire logic hit_stat = addr_hit(reg_addr_in, `PDM_ADDR_STATUS);
   wire logic wr_one = reg_wr_in & hit_one;
   wire logic wr_two = reg_wr_in & hit_two;

   logic [7:0] ctl_one_ff;
   logic [7:0] ctl_two_ff;
   logic [7:0] rdata_ff;

   // reserved bits are masked off, so they can never read back as one
   wire logic [7:0] nxt_ctl_one = wr_one ? (reg_wdata_in & `PDM_CTL_ONE_WMASK) :
      ctl_one_ff; // see [RULE_13]
   wire logic [7:0] nxt_ctl_two = wr_two ? (reg_wdata_in & `PDM_CTL_TWO_WMASK) :
      ctl_two_ff;

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ctl_one_ff <= `PDM_CTL_ONE_RST; // see [RULE_14]
         ctl_two_ff <= `PDM_CTL_TWO_RST;
      end
      else
      begin
         ctl_one_ff <= nxt_ctl_one;
         ctl_two_ff <= nxt_ctl_two;
      end
   end

   // ---- control fields
   // software is expected to have stopped the watchdog before this is set
   wire logic standby_select = ctl_one_ff[`PDM_BIT_STANDBY_SELECT]; // see [RULE_05]
   wire logic output_float_in_standby = ctl_one_ff[`PDM_BIT_OUTPUT_FLOAT];
   // stopping an active break controller is a software fault, not checked
   wire logic break_unit_stop = ctl_one_ff[`PDM_BIT_BREAK_STOP]; // see [RULE_07]
   wire logic dma_unit_stop = ctl_one_ff[`PDM_BIT_DMA_STOP];
   // dsp operand use while stopped is left to software
   wire logic dsp_unit_stop = ctl_one_ff[`PDM_BIT_DSP_STOP]; // see [RULE_11]
   wire logic free_timer_stop = ctl_one_ff[`PDM_BIT_FREE_TIMER_STOP];

   // ---- power mode sequencing
   pdm_pkg::pdm_mode_t mode_ff;
   pdm_pkg::pdm_mode_t nxt_mode;
   logic [CW-1:0] nmi_block_ff;
   logic [CW-1:0] nxt_nmi_block;

   wire logic nmi_blocked = sleep_exec_in | (nmi_block_ff != '0); // see [RULE_17]
   wire logic nmi_take = nmi_rise & ~nmi_blocked;
   wire logic sleep_wake = irq_accept_in | dma_addr_err_in | manual_reset; // see [RULE_16]
   wire logic standby_wake = nmi_take | manual_reset;

   always_comb
   begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         pdm_pkg::st_run:
         begin
            if (sleep_exec_in & ~manual_reset)
            begin
               if (standby_select)
                  nxt_mode = pdm_pkg::st_standby; // see [RULE_02]
               else
                  nxt_mode = pdm_pkg::st_sleep; // see [RULE_01]
            end
         end
         pdm_pkg::st_sleep:
         begin
            if (sleep_wake)
               nxt_mode = pdm_pkg::st_run; // see [RULE_16]
         end
         pdm_pkg::st_standby:
         begin
            if (standby_wake)
               nxt_mode = pdm_pkg::st_run;
         end
         default:
            nxt_mode = pdm_pkg::st_run;
      endcase
   end

   always_comb
   begin
      if (sleep_exec_in)
         nxt_nmi_block = BLOCK_LOAD; // see [RULE_17]
      else if (nmi_block_ff != '0)
         nxt_nmi_block = nmi_block_ff - CW'(1);
      else
         nxt_nmi_block = nmi_block_ff;
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         mode_ff <= pdm_pkg::st_run;
         nmi_block_ff <= '0;
      end
      else
      begin
         mode_ff <= nxt_mode;
         nmi_block_ff <= nxt_nmi_block;
      end
   end

   wire logic in_sleep = (mode_ff == pdm_pkg::st_sleep);
   wire logic in_standby = (mode_ff == pdm_pkg::st_standby);

   // ---- dma stop latching
   // the stop only takes hold once the dma is idle; until then a busy dma keeps its clock, after that busy is ignored
   logic dma_stopped_ff;
   wire logic nxt_dma_stopped = dma_unit_stop & (dma_stopped_ff | ~dma_busy_in); // see [RULE_09]

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         dma_stopped_ff <= 1'b0;
      else
         dma_stopped_ff <= nxt_dma_stopped;
   end

   // ---- clock gate requests
   pdm_gate_if #(.N(`PDM_GATE_COUNT)) gate_bus ();
   logic [`PDM_GATE_COUNT-1:0] stop_vec;

   always_comb
   begin
      stop_vec = '0;
      // sleep stops the cpu and dsp only; standby stops every module
      stop_vec[`PDM_CH_CPU] = in_sleep | in_standby; // see [RULE_03]
      stop_vec[`PDM_CH_DSP] = dsp_unit_stop | in_sleep | in_standby; // see [RULE_10]
      stop_vec[`PDM_CH_DMA] = dma_stopped_ff | in_standby; // see [RULE_08]
      stop_vec[`PDM_CH_BREAK] = break_unit_stop | in_standby; // see [RULE_06]
      stop_vec[`PDM_CH_TIMER] = free_timer_stop | in_standby; // see [RULE_12]
   end

   assign gate_bus.stop_req = stop_vec; // see [RULE_15]

   pdm_clk_gate #(.N(`PDM_GATE_COUNT)) u_gate (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .gate_if(gate_bus)
   );

   // ---- status word
   // bits 7..6 mode, bits 4..0 live gate enables
   wire logic [7:0] status_word = {in_standby, in_sleep, 1'b0, gate_bus.run_en};

   // ---- read port, data valid only in the cycle after the strobe
   wire logic [7:0] rd_mux = hit_one ? ctl_one_ff :
      hit_two ? ctl_two_ff :
      hit_stat ? status_word : 8'h00;

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         rdata_ff <= 8'h00;
      else if (reg_rd_in)
         rdata_ff <= rd_mux;
      else
         rdata_ff <= 8'h00;
   end

   // ---- registered mode outputs
   logic pin_float_ff;
   logic pin_hold_ff;
   logic timer_reset_ff;

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         pin_float_ff <= 1'b0;
         pin_hold_ff <= 1'b0;
         timer_reset_ff <= 1'b0;
      end
      else
      begin
         pin_float_ff <= (nxt_mode == pdm_pkg::st_standby) & output_float_in_standby; // see [RULE_04]
         pin_hold_ff <= (nxt_mode == pdm_pkg::st_standby) & ~output_float_in_standby;
         // timer held in reset while stopped so it restarts from its initial state
         timer_reset_ff <= nxt_ctl_one[`PDM_BIT_FREE_TIMER_STOP]; // see [RULE_12]
      end
   end

   assign reg_rdata_out = rdata_ff;
   assign nmi_accept_out = nmi_take; // see [RULE_17]
   assign sleep_mode_out = in_sleep;
   assign standby_mode_out = in_standby;
   assign cpu_halt_out = in_sleep | in_standby; // see [RULE_03]
   assign periph_halt_out = in_standby;
   assign osc_stop_out = in_standby; // see [RULE_03]
   assign pin_float_out = pin_float_ff;
   assign pin_hold_out = pin_hold_ff;
   assign timer_reset_out = timer_reset_ff;
   assign module_stop_two_out = ctl_two_ff[5:0];
   assign cpu_gclk_out = gate_bus.gclk[`PDM_CH_CPU];
   assign dsp_gclk_out = gate_bus.gclk[`PDM_CH_DSP];
   assign dma_gclk_out = gate_bus.gclk[`PDM_CH_DMA];
   assign break_gclk_out = gate_bus.gclk[`PDM_CH_BREAK];
   assign timer_gclk_out = gate_bus.gclk[`PDM_CH_TIMER];
endmodule : pdm_power_ctrl
`default_nettype wire

// [pdm_power_ctrl_chk.sv]
// checker: port timing of the power-down controller.
// assumes: bound onto pdm_power_ctrl; one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_power_ctrl_chk (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [31:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic sleep_exec_in,
   input wire logic irq_accept_in,
   input wire logic manual_reset_pin_in,
   input wire logic nmi_accept_out,
   input wire logic sleep_mode_out,
   input wire logic standby_mode_out,
   input wire logic cpu_halt_out,
   input wire logic periph_halt_out,
   input wire logic osc_stop_out,
   input wire logic pin_float_out,
   input wire logic pin_hold_out,
   input wire logic timer_reset_out
);
   logic [7:0] one_ff;
   logic [2:0] mr_ff;
   // a recent manual reset may veto a sleep request
   wire logic quiet = !manual_reset_pin_in && mr_ff == 3'h0;
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         one_ff <= 8'h00;
         mr_ff <= 3'h0;
      end
      else
      begin
         mr_ff <= {mr_ff[1:0], manual_reset_pin_in};
         if (reg_wr_in && reg_addr_in == `PDM_ADDR_CTL_ONE)
            one_ff <= reg_wdata_in & `PDM_CTL_ONE_WMASK;
      end
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   property p_sleep_in;
      sleep_exec_in && !cpu_halt_out && quiet && !one_ff[7] |=> sleep_mode_out
         && cpu_halt_out && !periph_halt_out && !osc_stop_out;
   endproperty
   a_sleep_in: assert property (p_sleep_in) else $error("bad sleep entry");
   property p_sby_in;
      sleep_exec_in && !cpu_halt_out && quiet && one_ff[7] |=> standby_mode_out
         && cpu_halt_out && periph_halt_out && osc_stop_out;
   endproperty
   a_sby_in: assert property (p_sby_in) else $error("bad standby entry");
   property p_pins;
      pin_float_out == (standby_mode_out && one_ff[6])
         && pin_hold_out == (standby_mode_out && !one_ff[6]);
   endproperty
   a_pins: assert property (p_pins) else $error("bad pin state");
   property p_rdback;
      $past(reg_rd_in) && $past(reg_addr_in) == `PDM_ADDR_CTL_ONE
         |-> reg_rdata_out == $past(one_ff);
   endproperty
   a_rdback: assert property (p_rdback) else $error("bad readback");
   property p_rd_idle;
      !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_timer;
      one_ff[1] |-> ##[0:1] timer_reset_out;
   endproperty
   a_timer: assert property (p_timer) else $error("timer not reset");
   property p_nmi_block;
      sleep_exec_in && !cpu_halt_out && quiet |-> !nmi_accept_out [*6];
   endproperty
   a_nmi_block: assert property (p_nmi_block) else $error("nmi in window");
   property p_wake;
      sleep_mode_out && irq_accept_in |=> !sleep_mode_out && !cpu_halt_out;
   endproperty
   a_wake: assert property (p_wake) else $error("sleep not left");
endmodule : pdm_power_ctrl_chk
bind pdm_power_ctrl pdm_power_ctrl_chk u_chk (.*);
`default_nettype wire

// [pdm_power_ctrl_tb.sv]
// bench: registers, modes, wake sources and clock gates of the controller.
// assumes: design and checker compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_power_ctrl_tb;
   logic mclk_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic sleep_exec_in = 1'b0, irq_accept_in = 1'b0, dma_addr_err_in = 1'b0;
   logic dma_busy_in = 1'b0, nmi_pin_in = 1'b0, manual_reset_pin_in = 1'b0;
   logic [31:0] reg_addr_in = 32'h0000_0000;
   logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, d;
   logic sleep_mode_out, standby_mode_out, cpu_halt_out, periph_halt_out, osc_stop_out;
   logic pin_float_out, pin_hold_out, timer_reset_out, nmi_accept_out;
   logic [5:0] module_stop_two_out;
   logic cpu_gclk_out, dsp_gclk_out, dma_gclk_out, break_gclk_out, timer_gclk_out;
   wire logic [7:0] gv = {3'h0, timer_gclk_out, break_gclk_out, dma_gclk_out,
      dsp_gclk_out, cpu_gclk_out};
   wire logic [7:0] mv = {3'h0, sleep_mode_out, standby_mode_out, cpu_halt_out,
      periph_halt_out, osc_stop_out};
   int n_mismatch = 0, check_count = 0, nmi_cnt = 0;
   pdm_power_ctrl dut (.*);
   // accept pulse is combinational, so count it on the falling edge where it is settled
   always @(negedge mclk_in)
      if (nmi_accept_out === 1'b1)
         nmi_cnt <= nmi_cnt + 1;
   function automatic logic [7:0] gate_exp(logic [7:0] c, logic [1:0] m);
      // dsp and cpu clocks also stop in sleep; standby stops all
      return (m == 2'h2) ? 8'h00 : {3'h0, ~c[1], ~c[5], ~c[4], ~c[3] & (m == 2'h0), m == 2'h0};
   endfunction : gate_exp
   task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task automatic tmo(logic ok);
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         final_report();
      end
   endtask : tmo
   task automatic tick(int n);
      // sample in the high phase so gated clocks are settled
      repeat (n) @(posedge mclk_in);
      #2;
   endtask : tick
   task automatic wr(logic [7:0] v, logic [31:0] a = `PDM_ADDR_CTL_ONE);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task automatic rchk(string n, logic [31:0] a, logic [7:0] e);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1 check(n, reg_rdata_out, e);
   endtask : rchk
   task automatic slp();
      @(posedge mclk_in);
      sleep_exec_in <= 1'b1;
      @(posedge mclk_in);
      sleep_exec_in <= 1'b0;
      #1;
   endtask : slp
   initial
   begin
      forever #5 mclk_in = ~mclk_in;
   end
   initial
   begin
      d = 8'($urandom(31675));
      repeat (2) @(posedge mclk_in);
      nrst_in <= 1'b1;
      rchk("one_rst", `PDM_ADDR_CTL_ONE, 8'h00);
      rchk("two_rst", `PDM_ADDR_CTL_TWO, 8'h00);
      rchk("unmapped", 32'hFFFF_FE92, 8'h00);
      wr(8'hFF, `PDM_ADDR_CTL_TWO);
      rchk("two", `PDM_ADDR_CTL_TWO, 8'h3F);
      check("stop_two", {2'h0, module_stop_two_out}, 8'h3F);
      wr(8'h00, `PDM_ADDR_CTL_TWO);
      // random stops assume idle break and dsp units
      for (int i = 0; i < 24; i++)
      begin
         d = (i == 0) ? 8'hFF : 8'($urandom);
         wr(d);
         rchk("one", `PDM_ADDR_CTL_ONE, d & 8'hFA);
         tick(1);
         check("tmr_rst", {7'h00, timer_reset_out}, {7'h00, d[1]});
         check("gates", gv, gate_exp(d, 2'h0));
      end
      // stop must wait while a transfer runs, then hold
      dma_busy_in <= 1'b1;
      wr(8'h10);
      tick(4);
      check("dma_busy", gv, 8'h1F);
      dma_busy_in <= 1'b0;
      tick(4);
      check("dma_idle", gv, 8'h1B);
      dma_busy_in <= 1'b1;
      tick(4);
      check("dma_hold", gv, 8'h1B);
      dma_busy_in <= 1'b0;
      wr(8'h00);
      for (int w = 0; w < 3; w++)
      begin
         slp();
         check("sleep", mv, 8'h14);
         tick(3);
         check("sleep_gates", gv, gate_exp(8'h00, 2'h1));
         irq_accept_in <= (w == 0);
         dma_addr_err_in <= (w == 1);
         manual_reset_pin_in <= (w == 2);
         tick(1);
         irq_accept_in <= 1'b0;
         dma_addr_err_in <= 1'b0;
         manual_reset_pin_in <= 1'b0;
         for (int k = 0; k < 8 && cpu_halt_out !== 1'b0; k++)
            tick(1);
         tmo(cpu_halt_out === 1'b0);
         check("sleep_wake", mv, 8'h00);
      end
      for (int f = 0; f < 2; f++)
      begin
         // watchdog taken as already stopped here
         d = {1'b1, f[0], 6'h00};
         wr(d);
         slp();
         // this rise falls inside the blocking window and is lost
         nmi_pin_in <= 1'b1;
         check("standby", mv, 8'h0F);
         check("pins", {6'h00, pin_float_out, pin_hold_out}, {6'h00, f[0], ~f[0]});
         tick(10);
         check("nmi_block", mv, 8'h0F);
         check("sby_gates", gv, gate_exp(d, 2'h2));
         nmi_pin_in <= 1'b0;
         tick(4);
         nmi_pin_in <= 1'b1;
         for (int k = 0; k < 10 && standby_mode_out !== 1'b0; k++)
            tick(1);
         tmo(standby_mode_out === 1'b0);
         check("nmi_wake", mv, 8'h00);
         nmi_pin_in <= 1'b0;
      end
      tick(2);
      check("nmi_acc", 8'(nmi_cnt), 8'h02);
      final_report();
   end
endmodule : pdm_power_ctrl_tb
`default_nettype wire
